// *** mst_pkg.sv ***
// constants, field layouts and types for the mmu control and shadow tlb
package mst_pkg;
    localparam int XW       = 32;
    localparam int PTW      = 8;
    localparam int PGW      = 12;
    localparam int EPNW     = XW - PGW;
    localparam int I_ENT    = 4;
    localparam int D_ENT    = 8;
    localparam int I_IDXW   = 2;
    localparam int D_IDXW   = 3;
    localparam int PENALTY_CYC = 3;
    // mmu_control fields, little-endian index (bit 31 - printed position)
    localparam int MC_NOALLOC_POS  = 24;
    localparam int MC_PGALLOC_POS  = 21;
    localparam int MC_DFLUSH_POS   = 19;
    localparam int MC_IINVAL_POS   = 18;
    localparam int MC_SPACE_POS    = 16;
    localparam int MC_IDENT_LSB    = 0;
    localparam logic [XW-1:0]  MC_RESET  = 32'h0000_0000;
    localparam logic [PTW-1:0] PID_RESET = 8'h00;
    localparam logic [PTW-1:0] GLOBAL_TAG = 8'h00;
    localparam logic [XW-PTW-1:0] PID_RSVD = 24'h00_0000;

    typedef struct packed {
        logic            valid;
        logic            space;
        logic [PTW-1:0]  tag;
        logic [EPNW-1:0] epn;
        logic [EPNW-1:0] rpn;
        logic            u2;
        logic            wt;
    } mst_entry_t;

    typedef struct packed {
        logic            req;
        logic [XW-1:0]   ea;
    } mst_access_t;

    typedef enum logic [0:0] {
        MST_SPR_PID    = 1'b0,
        MST_SPR_MMUCTL = 1'b1
    } mst_spr_t;

    typedef enum logic [1:0] {
        MST_IDLE = 2'b00,
        MST_LOOK = 2'b01,
        MST_FILL = 2'b10
    } mst_state_t;
endpackage

// *** mst_top.sv ***
// mmu control fields, process ident register and shadow translation arrays
// Notes on behaviour
// - page-attr enable 0: global no-allocate field alone decides store alloc
// - page-attr enable 1: ignore global field, page user attr two decides
// - page control, attr two 0: store miss allocates line
// - no allocate: store goes to memory only, write-through ignored
// - flush lock enable and user mode: data flush raises lock exception
// - invalidate lock enable and user mode: icache invalidate raises it
// - lock exception raised regardless of line lock or hit
// - flush enable 0 or supervisor: data flush proceeds normally
// - invalidate enable 0 or supervisor: invalidate proceeds normally
// - space bit vs instr/data space bit, search space for search
// - tag vs process ident for accesses, search ident for search
// - entry word 0 read/write moves tag via search ident field
// - process ident register 32 bits, only low 8 defined
// - entry tag 0 is global, process ident ignored
// - process ident written by move-to, read by move-from
// - four-entry instr shadow array, eight-entry data shadow array
// - shadow hit adds no latency
// - shadow miss stalls, unified lookup, three-cycle penalty on hit
// - unified miss reports instr or data translation miss exception
// - round-robin refill replaces oldest shadow entry
// - any context synchronization invalidates both shadow arrays
// - unified entry write neither synchronizes nor touches shadows
`timescale 1ns/10ps
`default_nettype none
module mst_top
    import mst_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    input  wire logic                     clk_en,
    // special register move port
    input  wire logic                     spr_wr,
    input  wire logic                     spr_rd,
    input  wire mst_pkg::mst_spr_t        spr_sel,
    input  wire logic [mst_pkg::XW-1:0]   spr_wdata,
    output logic [mst_pkg::XW-1:0]        spr_rdata,
    // machine state
    input  wire logic                     problem_state_bit,
    input  wire logic                     instr_space_bit,
    input  wire logic                     data_space_bit,
    input  wire logic                     ctx_sync,
    // fetch and data accesses
    input  wire mst_pkg::mst_access_t     if_acc,
    output logic                          if_ready,
    output logic [mst_pkg::XW-1:0]        if_pa,
    output logic                          if_tlb_miss_exc,
    input  wire mst_pkg::mst_access_t     d_acc,
    output logic                          d_ready,
    output logic [mst_pkg::XW-1:0]        d_pa,
    output logic                          d_tlb_miss_exc,
    // store miss allocation
    input  wire logic                     st_cache_miss,
    output logic                          st_allocate,
    output logic                          st_mem_only,
    // cache management lock checks
    input  wire logic                     dflush_op,
    input  wire logic                     iinval_op,
    output logic                          dflush_go,
    output logic                          iinval_go,
    output logic                          lock_dsi_exc,
    // unified array lookup port
    output logic                          unified_xlate_array_req,
    output logic                          unified_xlate_array_space,
    output logic [mst_pkg::PTW-1:0]       unified_xlate_array_tag,
    output logic [mst_pkg::EPNW-1:0]      unified_xlate_array_epn,
    input  wire logic                     unified_xlate_array_hit,
    input  wire mst_pkg::mst_entry_t      unified_xlate_array_entry,
    // search and word-0 transfer
    output logic                          srch_space,
    output logic [mst_pkg::PTW-1:0]       srch_tag,
    input  wire logic                     tlbre_w0,
    input  wire logic [mst_pkg::PTW-1:0]  tlbre_w0_tag,
    output logic [mst_pkg::PTW-1:0]       tlbwe_w0_tag
);
    import mst_pkg::*;

    function automatic logic entry_match(
        input mst_entry_t     e,
        input logic           space,
        input logic [PTW-1:0] process_ident_reg,
        input logic [XW-1:0]  ea
    );
        entry_match = e.valid && (e.space == space) &&
                      (e.epn == ea[XW-1:PGW]) &&
                      ((e.tag == GLOBAL_TAG) || (e.tag == process_ident_reg));
    endfunction

    logic [XW-1:0]     mmu_control_q;
    logic [PTW-1:0]    process_ident_q;
    logic [XW-1:0]     rdata_q;
    mst_entry_t        ishadow_q [I_ENT];
    mst_entry_t        dshadow_q [D_ENT];
    logic [I_IDXW-1:0] irr_q;
    logic [D_IDXW-1:0] drr_q;
    mst_state_t        state_q;
    logic              miss_data_q;
    logic              miss_space_q;
    logic [EPNW-1:0]   miss_epn_q;
    mst_entry_t        fill_q;

    logic global_no_alloc;
    logic page_attr_alloc_enable;
    logic dflush_lock_exc_enable;
    logic iinval_lock_exc_enable;
    logic [PTW-1:0] search_ident_field;

    assign global_no_alloc        = mmu_control_q[MC_NOALLOC_POS];
    assign page_attr_alloc_enable = mmu_control_q[MC_PGALLOC_POS];
    assign dflush_lock_exc_enable = mmu_control_q[MC_DFLUSH_POS];
    assign iinval_lock_exc_enable = mmu_control_q[MC_IINVAL_POS];
    assign search_ident_field     = mmu_control_q[MC_IDENT_LSB +: PTW];
    assign srch_space = mmu_control_q[MC_SPACE_POS];
    assign srch_tag   = search_ident_field;
    assign tlbwe_w0_tag = search_ident_field;

    // special registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            process_ident_q <= PID_RESET;
        end else if (clk_en && spr_wr && spr_sel == MST_SPR_PID) begin
            process_ident_q <= spr_wdata[PTW-1:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mmu_control_q <= MC_RESET;
        end else if (clk_en) begin
            if (spr_wr && spr_sel == MST_SPR_MMUCTL) begin
                mmu_control_q <= spr_wdata;
            end
            // entry read of word 0 lands its tag here, not in the gpr
            if (tlbre_w0) begin
                mmu_control_q[MC_IDENT_LSB +: PTW] <= tlbre_w0_tag;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= '0;
        end else if (clk_en && spr_rd) begin
            if (spr_sel == MST_SPR_PID) begin
                rdata_q <= {PID_RSVD, process_ident_q};
            end else begin
                rdata_q <= mmu_control_q;
            end
        end
    end
    assign spr_rdata = rdata_q;

    // shadow lookups, zero added latency on a hit
    logic [I_ENT-1:0] ihit_vec;
    logic [D_ENT-1:0] dhit_vec;
    mst_entry_t       ient;
    mst_entry_t       dent;

    for (genvar i = 0; i < I_ENT; i++) begin : g_imatch
        assign ihit_vec[i] = entry_match(ishadow_q[i], instr_space_bit,
            process_ident_q, if_acc.ea);
    end
    for (genvar i = 0; i < D_ENT; i++) begin : g_dmatch
        assign dhit_vec[i] = entry_match(dshadow_q[i], data_space_bit,
                                         process_ident_q, d_acc.ea);
    end

    always_comb begin
        ient = '0;
        for (int k = 0; k < I_ENT; k++) begin
            if (ihit_vec[k]) begin
                ient = ishadow_q[k];
            end
        end
    end
    always_comb begin
        dent = '0;
        for (int k = 0; k < D_ENT; k++) begin
            if (dhit_vec[k]) begin
                dent = dshadow_q[k];
            end
        end
    end

    logic ihit;
    logic dhit;
    assign ihit = |ihit_vec;
    assign dhit = |dhit_vec;
    // hit passes straight through; a miss holds ready low (stall)
    assign if_ready = if_acc.req && ihit;
    assign d_ready  = d_acc.req && dhit;
    assign if_pa = {ient.rpn, if_acc.ea[PGW-1:0]};
    assign d_pa  = {dent.rpn, d_acc.ea[PGW-1:0]};

    // store miss allocation choice
    logic alloc;
    always_comb begin
        if (page_attr_alloc_enable) begin
            alloc = !dent.u2;
        end else begin
            alloc = !global_no_alloc;
        end
    end
    assign st_allocate = d_ready && st_cache_miss && alloc;
    // write-through attribute has no say once allocation is off
    assign st_mem_only = d_ready && st_cache_miss && !alloc;

    // decided ahead of the cache lookup, so lock and hit state never enter
    logic dlock;
    logic ilock;
    assign dlock = dflush_op && dflush_lock_exc_enable &&
                   problem_state_bit;
    assign ilock = iinval_op && iinval_lock_exc_enable &&
                   problem_state_bit;
    assign lock_dsi_exc = dlock || ilock;
    assign dflush_go = dflush_op && !dlock;
    assign iinval_go = iinval_op && !ilock;

    // miss sequencer: miss cycle, look, fill gives three lost cycles
    logic imiss;
    logic dmiss;
    logic look_miss;
    assign imiss = if_acc.req && !ihit;
    assign dmiss = d_acc.req && !dhit;
    assign look_miss = (state_q == MST_LOOK) && !unified_xlate_array_hit;
    assign if_tlb_miss_exc = look_miss && !miss_data_q;
    assign d_tlb_miss_exc  = look_miss && miss_data_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= MST_IDLE;
        end else if (clk_en) begin
            case (state_q)
                MST_IDLE: begin
                    if ((imiss || dmiss) && !ctx_sync) begin
                        state_q <= MST_LOOK;
                    end
                end
                MST_LOOK: begin
                    if (unified_xlate_array_hit && !ctx_sync) begin
                        state_q <= MST_FILL;
                    end else begin
                        state_q <= MST_IDLE;
                    end
                end
                MST_FILL: begin
                    state_q <= MST_IDLE;
                end
                default: begin
                    state_q <= MST_IDLE;
                end
            endcase
        end
    end

    // data misses win the shared unified port over fetch misses
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            miss_data_q  <= 1'b0;
            miss_space_q <= 1'b0;
            miss_epn_q   <= '0;
        end else if (clk_en && state_q == MST_IDLE) begin
            if (dmiss) begin
                miss_data_q  <= 1'b1;
                miss_space_q <= data_space_bit;
                miss_epn_q   <= d_acc.ea[XW-1:PGW];
            end else if (imiss) begin
                miss_data_q  <= 1'b0;
                miss_space_q <= instr_space_bit;
                miss_epn_q   <= if_acc.ea[XW-1:PGW];
            end
        end
    end

    assign unified_xlate_array_req   = (state_q == MST_LOOK);
    assign unified_xlate_array_space = miss_space_q;
    assign unified_xlate_array_tag   = process_ident_q;
    assign unified_xlate_array_epn   = miss_epn_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fill_q <= '0;
        end else if (clk_en && state_q == MST_LOOK) begin
            fill_q       <= unified_xlate_array_entry;
            fill_q.valid <= 1'b1;
        end
    end

    // a sync during a refill drops the fill so nothing stale survives
    logic fill_en;
    assign fill_en = (state_q == MST_FILL) && !ctx_sync;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irr_q <= '0;
            drr_q <= '0;
        end else if (clk_en && fill_en) begin
            if (miss_data_q) begin
                drr_q <= drr_q + 1'b1;
            end else begin
                irr_q <= irr_q + 1'b1;
            end
        end
    end

    // unified entry writes have no path in here, so shadows stay put
    for (genvar i = 0; i < I_ENT; i++) begin : g_ientry
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                ishadow_q[i] <= '0;
            end else if (clk_en) begin
                if (ctx_sync) begin
                    ishadow_q[i].valid <= 1'b0;
                end else if (fill_en && !miss_data_q &&
                             irr_q == I_IDXW'(i)) begin
                    ishadow_q[i] <= fill_q;
                end
            end
        end
    end
    for (genvar i = 0; i < D_ENT; i++) begin : g_dentry
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                dshadow_q[i] <= '0;
            end else if (clk_en) begin
                if (ctx_sync) begin
                    dshadow_q[i].valid <= 1'b0;
                end else if (fill_en && miss_data_q &&
                             drr_q == D_IDXW'(i)) begin
                    dshadow_q[i] <= fill_q;
                end
            end
        end
    end
endmodule // mst_top
`default_nettype wire

// *** mst_unified_xlate_array_model.sv ***
// unified translation array stand-in answering lookups in the same cycle
`timescale 1ns/10ps
`default_nettype none
module mst_unified_xlate_array_model (
    input  wire logic                   unified_xlate_array_req,
    input  wire logic                   unified_xlate_array_space,
    input  wire logic [mst_pkg::PTW-1:0]  unified_xlate_array_tag,
    input  wire logic [mst_pkg::EPNW-1:0] unified_xlate_array_epn,
    output logic                        unified_xlate_array_hit,
    output mst_pkg::mst_entry_t         unified_xlate_array_entry
);
    import mst_pkg::*;
    mst_entry_t e;
    // pages 0..15 mapped; attr two follows the page's low bit
    assign e = '{valid: 1'b1, space: unified_xlate_array_space, tag: unified_xlate_array_tag,
                 epn: unified_xlate_array_epn, rpn: unified_xlate_array_epn + 20'h00080,
                 u2: unified_xlate_array_epn[0], wt: 1'b1};
    assign unified_xlate_array_hit = unified_xlate_array_req && (unified_xlate_array_epn < 20'h00010);
    // idle answer is scrambled so stale data never looks usable
    assign unified_xlate_array_entry = unified_xlate_array_req ? e : ~e;
endmodule // mst_unified_xlate_array_model
`default_nettype wire

// *** mst_top_props.sv ***
// concurrent checks on the mmu control and shadow array ports
`timescale 1ns/10ps
`default_nettype none
module mst_top_props (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic problem_state_bit,
    input wire logic ctx_sync,
    input wire logic d_ready,
    input wire logic if_ready,
    input wire logic d_tlb_miss_exc,
    input wire logic if_tlb_miss_exc,
    input wire logic st_cache_miss,
    input wire logic st_allocate,
    input wire logic st_mem_only,
    input wire logic dflush_op,
    input wire logic iinval_op,
    input wire logic dflush_go,
    input wire logic iinval_go,
    input wire logic lock_dsi_exc,
    input wire logic unified_xlate_array_req,
    input wire logic unified_xlate_array_hit
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    lock_src_a: assert property (
        lock_dsi_exc |-> problem_state_bit && (dflush_op || iinval_op))
        else $error("lock exception without user-mode operation");
    lock_block_a: assert property (
        lock_dsi_exc |-> !dflush_go && !iinval_go)
        else $error("operation proceeds despite lock exception");
    sup_flush_a: assert property (
        dflush_op && !problem_state_bit |-> dflush_go && !lock_dsi_exc)
        else $error("supervisor flush did not proceed");
    sup_inval_a: assert property (
        iinval_op && !problem_state_bit |-> iinval_go && !lock_dsi_exc)
        else $error("supervisor invalidate did not proceed");
    store_one_a: assert property (
        d_ready && st_cache_miss |-> st_allocate != st_mem_only)
        else $error("store miss not exactly one of allocate or memory");
    look_one_a: assert property (
        unified_xlate_array_req |=> !unified_xlate_array_req)
        else $error("unified lookup longer than one cycle");
    fill_pen_a: assert property (
        unified_xlate_array_req && unified_xlate_array_hit && !ctx_sync ##1 !ctx_sync
        |=> d_ready || if_ready) else $error("refill not ready on time");
    miss_exc_a: assert property (
        unified_xlate_array_req && !unified_xlate_array_hit |-> d_tlb_miss_exc || if_tlb_miss_exc)
        else $error("unified miss not reported");
    sync_inv_a: assert property (
        ctx_sync |=> !d_ready && !if_ready)
        else $error("shadow hit after context sync");
    fill_c: cover property (unified_xlate_array_req && unified_xlate_array_hit);
    miss_c: cover property (unified_xlate_array_req && !unified_xlate_array_hit);
    lock_c: cover property (lock_dsi_exc);
endmodule // mst_top_props
bind mst_top mst_top_props u_props (
    .clk(clk), .arst_n(arst_n), .problem_state_bit(problem_state_bit),
    .ctx_sync(ctx_sync), .d_ready(d_ready), .if_ready(if_ready),
    .d_tlb_miss_exc(d_tlb_miss_exc), .if_tlb_miss_exc(if_tlb_miss_exc),
    .st_cache_miss(st_cache_miss), .st_allocate(st_allocate),
    .st_mem_only(st_mem_only), .dflush_op(dflush_op),
    .iinval_op(iinval_op), .dflush_go(dflush_go), .iinval_go(iinval_go),
    .lock_dsi_exc(lock_dsi_exc), .unified_xlate_array_req(unified_xlate_array_req), .unified_xlate_array_hit(unified_xlate_array_hit)
);
`default_nettype wire

// *** mst_top_tb.sv ***
// self-checking bench for mmu control fields and shadow arrays
`timescale 1ns/10ps
`default_nettype none
module mst_top_tb;
    import mst_pkg::*;
    logic clk, arst_n, spr_wr, spr_rd, pr, isb, dsb, ctx_sync, st_miss;
    logic if_ready, if_exc, d_ready, d_exc, st_alloc, st_mem, dfl, iiv;
    logic dfl_go, iiv_go, lock_exc, u_req, u_sp, u_hit, s_sp, w0, al;
    logic [31:0] wdata, rdata, if_pa, d_pa;
    logic [7:0]  u_tag, s_tag, w0_in, w0_out;
    logic [19:0] u_epn;
    mst_spr_t    sel;
    mst_access_t if_acc, d_acc;
    mst_entry_t  u_ent;
    int errors, n_checks, cyc, n, m, pg;
    mst_top u_dut (.clk(clk), .arst_n(arst_n), .clk_en(1'b1),
        .spr_wr(spr_wr), .spr_rd(spr_rd), .spr_sel(sel),
        .spr_wdata(wdata), .spr_rdata(rdata), .problem_state_bit(pr),
        .instr_space_bit(isb), .data_space_bit(dsb), .ctx_sync(ctx_sync),
        .if_acc(if_acc), .if_ready(if_ready), .if_pa(if_pa),
        .if_tlb_miss_exc(if_exc), .d_acc(d_acc), .d_ready(d_ready),
        .d_pa(d_pa), .d_tlb_miss_exc(d_exc), .st_cache_miss(st_miss),
        .st_allocate(st_alloc), .st_mem_only(st_mem), .dflush_op(dfl),
        .iinval_op(iiv), .dflush_go(dfl_go), .iinval_go(iiv_go),
        .lock_dsi_exc(lock_exc), .unified_xlate_array_req(u_req), .unified_xlate_array_space(u_sp),
        .unified_xlate_array_tag(u_tag), .unified_xlate_array_epn(u_epn), .unified_xlate_array_hit(u_hit),
        .unified_xlate_array_entry(u_ent), .srch_space(s_sp), .srch_tag(s_tag),
        .tlbre_w0(w0), .tlbre_w0_tag(w0_in), .tlbwe_w0_tag(w0_out));
    mst_unified_xlate_array_model u_unified_xlate_array (.unified_xlate_array_req(u_req), .unified_xlate_array_space(u_sp),
        .unified_xlate_array_tag(u_tag), .unified_xlate_array_epn(u_epn), .unified_xlate_array_hit(u_hit),
        .unified_xlate_array_entry(u_ent));
    always #4 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            end_sim();
        end
    end
    task automatic spr(input logic w, input mst_spr_t s, input logic [31:0] v);
        @(posedge clk);
        spr_wr <= w;
        spr_rd <= !w;
        sel <= s;
        wdata <= v;
        @(posedge clk);
        spr_wr <= 1'b0;
        spr_rd <= 1'b0;
        #1;
    endtask
    // holds the request until ready, a miss exception or 9 stalls; c counts stalls
    task automatic acc(input logic d, input logic [31:0] ea, output int c);
        @(posedge clk);
        if (d) begin
            d_acc <= '{1'b1, ea};
        end else begin
            if_acc <= '{1'b1, ea};
        end
        #1;
        c = 0;
        while (!(d ? d_ready || d_exc : if_ready || if_exc) && c < 9) begin
            @(posedge clk);
            #1;
            c++;
            if (c == 1 && u_hit) begin
                chk({u_sp, u_tag, u_epn},
                    {d ? dsb : isb, 8'h12, ea[31:12]});
            end
        end
        if (d ? d_ready : if_ready) begin
            chk(d ? d_pa : if_pa, {ea[31:12] + 20'h00080, ea[11:0]});
        end
    endtask
    task automatic idle();
        @(posedge clk);
        d_acc.req <= 1'b0;
        if_acc.req <= 1'b0;
    endtask
    initial begin
        {clk, arst_n, spr_wr, spr_rd, pr, isb, dsb, ctx_sync, st_miss} = '0;
        {dfl, iiv, w0, w0_in, wdata, if_acc, d_acc} = '0;
        sel = MST_SPR_PID;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk(rdata, 32'h0);
        chk({s_sp, s_tag, w0_out, u_req, d_ready, if_ready}, 20'h0);
        spr(1'b1, MST_SPR_PID, 32'hFFFF_FF12);
        spr(1'b0, MST_SPR_PID, 32'h0);
        chk(rdata, 32'h0000_0012);
        spr(1'b1, MST_SPR_MMUCTL, 32'h0001_00C3);
        chk({s_sp, s_tag}, 9'h1C3);
        @(posedge clk);
        w0 <= 1'b1;
        w0_in <= 8'h5A;
        @(posedge clk);
        w0 <= 1'b0;
        #1;
        chk({s_tag, w0_out}, 16'h5A5A);
        for (int i = 0; i < 8; i++) begin
            spr(1'b1, MST_SPR_MMUCTL, i[0] ? 32'h000C_0000 : 32'h0);
            @(posedge clk);
            pr <= i[1];
            dfl <= !i[2];
            iiv <= i[2];
            #1;
            al = i[0] & i[1];
            chk({lock_exc, dfl_go, iiv_go},
                {al, !i[2] & !al, i[2] & !al});
        end
        @(posedge clk);
        {dfl, iiv, pr} <= 3'h0;
        dsb <= 1'b1;
        // fetch array first, then data: fill past capacity and revisit
        for (int p = 0; p < 2; p++) begin
            m = p ? 8 : 4;
            for (int k = 0; k < m + 4; k++) begin
                pg = (k <= m) ? k : (k == m + 1) ? 0 : (k == m + 2) ? 2 : m;
                acc(p[0], {pg[19:0], 12'h0AB}, n);
                chk(n, (k <= m + 1) ? 3 : 0);
            end
            idle();
        end
        st_miss <= 1'b1;
        for (int j = 0; j < 8; j++) begin
            spr(1'b1, MST_SPR_MMUCTL, {7'h0, j[1], 2'h0, j[0], 21'h0});
            acc(1'b1, {j[2] ? 20'h00003 : 20'h00002, 12'h000}, n);
            al = j[0] ? !j[2] : !j[1];
            chk({n[1:0], st_alloc, st_mem}, {2'h0, al, !al});
        end
        idle();
        acc(1'b1, 32'h0010_0000, n);
        chk({d_exc, n[3:0]}, 5'h11);
        idle();
        acc(1'b0, 32'h0020_0000, n);
        chk({if_exc, n[3:0]}, 5'h11);
        idle();
        acc(1'b1, 32'h0000_4000, n);
        chk(n, 0);
        idle();
        ctx_sync <= 1'b1;
        @(posedge clk);
        ctx_sync <= 1'b0;
        acc(1'b1, 32'h0000_4000, n);
        chk(n, 3);
        idle();
        end_sim();
    end
endmodule // mst_top_tb
`default_nettype wire
